// *** scrbm_consts.svh ***
`ifndef SCRBM_CONSTS_SVH
`define SCRBM_CONSTS_SVH

// ----------------------------------------------------------------
// APB register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define SCRBM_OFS_CONFIG 8'h00
`define SCRBM_OFS_POSITION 8'h04
`define SCRBM_OFS_STATUS 8'h08
`define SCRBM_OFS_REFUSED 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCRBM_BIT_WDOG_DIS 2
`define SCRBM_BIT_ROM_EN 1
`define SCRBM_POS_MSB 3
`define SCRBM_ST_SPECIAL 0
`define SCRBM_ST_WIN_OPEN 1
`define SCRBM_ST_MODE_LSB 2
`define SCRBM_ST_MODE_MSB 3
`define SCRBM_ST_WDOG_USED 4
`define SCRBM_ST_POS_USED 5
`define SCRBM_RF_CFG 0
`define SCRBM_RF_POS 1
`define SCRBM_RF_CNT_LSB 8
`define SCRBM_RF_CNT_MSB 15

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SCRBM_POS_RESET 4'h1
`define SCRBM_WIN_CYCLES 64
`define SCRBM_CNT_MAX 8'hff

// ----------------------------------------------------------------
// Memory map figures
// ----------------------------------------------------------------
`define SCRBM_ROM_BASE 16'hc000
`define SCRBM_REGBLK_LSB 7
`define SCRBM_REGBLK_PAD 5'h00
`define SCRBM_PAGE_LSB 12

`endif

// *** scrbm_pkg.sv ***
`default_nettype none

package scrbm_pkg;

	// Operating mode as caught from the straps {mode_b, mode_a}
	typedef enum logic [1:0] {
		SCRBM_MODE_BOOT = 2'b00,
		SCRBM_MODE_TEST = 2'b01,
		SCRBM_MODE_SINGLE = 2'b10,
		SCRBM_MODE_EXPAND = 2'b11
	} scrbm_mode_t;

	// Write window after reset release
	typedef enum logic [1:0] {
		SCRBM_WIN_OPEN = 2'b00,
		SCRBM_WIN_SHUT = 2'b01
	} scrbm_win_t;

endpackage

`default_nettype wire

// *** scrbm_wdog_gate.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Watchdog timeout to system reset gate
// ----------------------------------------------------------------
module scrbm_wdog_gate (
	input wire logic mclk,
	input wire logic srst,
	input wire logic wdog_timeout,
	input wire logic watchdog_disable,
	output logic sys_reset_req
);

	logic sys_reset_req_ff;

	// Registered so the reset request cannot glitch on a late timeout edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			sys_reset_req_ff <= 1'b0;
		end else begin
			sys_reset_req_ff <= wdog_timeout & ~watchdog_disable;
		end
	end

	assign sys_reset_req = sys_reset_req_ff;

endmodule

`default_nettype wire

// *** scrbm_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "scrbm_consts.svh"

// ----------------------------------------------------------------
// Memory map decode for register block and on-chip ROM
// ----------------------------------------------------------------
module scrbm_decode (
	input wire logic [15:0] mem_addr,
	input wire logic rom_map_enable,
	input wire logic [3:0] reg_block_page,
	output logic regs_sel,
	output logic rom_sel,
	output logic [6:0] regs_offset
);

	logic in_page;
	logic in_block;

	// 128-byte block at the start of the chosen 4 KiB page
	assign in_page = (mem_addr[15:`SCRBM_PAGE_LSB] == reg_block_page);
	assign in_block = (mem_addr[`SCRBM_PAGE_LSB-1:`SCRBM_REGBLK_LSB] == `SCRBM_REGBLK_PAD);
	assign regs_sel = in_page & in_block;
	assign regs_offset = mem_addr[`SCRBM_REGBLK_LSB-1:0];

	// Registers win over ROM where they overlap
	assign rom_sel = rom_map_enable & (mem_addr >= `SCRBM_ROM_BASE) & ~regs_sel;

endmodule

`default_nettype wire

// *** scrbm_top.sv ***
// Functional notes
// - Normal mode: watchdog disable written once, only in first 64 cycles.
// - Special mode: watchdog disable writable at any time, no restriction.
// - Reset: watchdog disable is 0 in normal mode, 1 in special mode.
// - Watchdog disable 0: a watchdog timeout forces system reset.
// - Watchdog disable 1: a watchdog timeout causes no reset.
// - ROM map enable ignores writes in normal mode; writable in special.
// - ROM map enable resets to 1 except normal expanded mode, where 0.
// - ROM map enable 1: ROM answers addresses C000 to FFFF.
// - ROM map enable 0: ROM answers no address.
// - Register block is 128 contiguous bytes on any 4 KiB boundary.
// - Register block sits at 1000 unless software moves it.
// - Block base top nibble comes from position register, resets to 1.
// - Registers win over overlapped ROM, which becomes unreachable.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

`include "scrbm_consts.svh"

module scrbm_top #(
	parameter int WIN_CYCLES = `SCRBM_WIN_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	// Mode straps, sampled during reset
	input wire logic mode_a_strap,
	input wire logic mode_b_strap,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core address decode
	input wire logic [15:0] mem_addr,
	output logic regs_sel,
	output logic rom_sel,
	output logic [6:0] regs_offset,
	// Watchdog
	input wire logic wdog_timeout,
	output logic sys_reset_req,
	// Configuration seen by the rest of the chip
	output logic watchdog_disable,
	output logic rom_map_enable,
	output logic special_mode_flag,
	output logic [3:0] register_block_position
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(WIN_CYCLES + 1);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYCLES - 1);

	scrbm_pkg::scrbm_mode_t mode_ff;
	scrbm_pkg::scrbm_win_t win_ff;
	scrbm_pkg::scrbm_win_t nxt_win;
	logic [CNT_W-1:0] win_cnt_ff;
	logic [CNT_W-1:0] nxt_win_cnt;
	logic wdog_dis_ff;
	logic rom_en_ff;
	logic [3:0] pos_ff;
	logic wdog_used_ff;
	logic pos_used_ff;
	logic cfg_refused_ff;
	logic pos_refused_ff;
	logic [7:0] refused_cnt_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic special;
	logic win_open;
	logic setup_ph;
	logic access_ph;
	logic wr_lane0;
	logic hit_cfg;
	logic hit_pos;
	logic hit_status;
	logic hit_refused;
	logic hit_any;
	logic wr_cfg;
	logic wr_pos;
	logic wr_refused;
	logic wdog_wr_ok;
	logic pos_wr_ok;
	logic cfg_refuse_ev;
	logic pos_refuse_ev;
	logic [31:0] rd_word;
	logic [31:0] status_word;
	logic [31:0] refused_word;

	// ----------------------------------------------------------------
	// Mode capture
	// ----------------------------------------------------------------

	// Straps are caught by the clocked reset, held steady afterwards
	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_ff <= scrbm_pkg::scrbm_mode_t'({mode_b_strap, mode_a_strap});
		end
	end

	// Boot and test modes are the special modes
	assign special = (mode_ff == scrbm_pkg::SCRBM_MODE_BOOT) |
		(mode_ff == scrbm_pkg::SCRBM_MODE_TEST);

	// ----------------------------------------------------------------
	// Write window after reset release
	// ----------------------------------------------------------------

	// Next window state: open for WIN_CYCLES clocks, then shut for good
	always_comb begin
		nxt_win = win_ff;
		nxt_win_cnt = win_cnt_ff;
		case (win_ff)
			scrbm_pkg::SCRBM_WIN_OPEN: begin
				nxt_win_cnt = win_cnt_ff + CNT_W'(1);
				if (win_cnt_ff == WIN_LAST) begin
					nxt_win = scrbm_pkg::SCRBM_WIN_SHUT;
				end
			end
			scrbm_pkg::SCRBM_WIN_SHUT: begin
				nxt_win = scrbm_pkg::SCRBM_WIN_SHUT;
			end
			default: begin
				nxt_win = scrbm_pkg::SCRBM_WIN_SHUT;
			end
		endcase
	end

	// Counter starts at zero on the first edge after release
	always_ff @(posedge mclk) begin
		if (srst) begin
			win_ff <= scrbm_pkg::SCRBM_WIN_OPEN;
			win_cnt_ff <= '0;
		end else begin
			win_ff <= nxt_win;
			win_cnt_ff <= nxt_win_cnt;
		end
	end

	assign win_open = (win_ff == scrbm_pkg::SCRBM_WIN_OPEN);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_lane0 = access_ph & pwrite & pstrb[0];

	// Address decode by comparison chain
	always_comb begin
		hit_cfg = 1'b0;
		hit_pos = 1'b0;
		hit_status = 1'b0;
		hit_refused = 1'b0;
		if (paddr == `SCRBM_OFS_CONFIG) begin
			hit_cfg = 1'b1;
		end else if (paddr == `SCRBM_OFS_POSITION) begin
			hit_pos = 1'b1;
		end else if (paddr == `SCRBM_OFS_STATUS) begin
			hit_status = 1'b1;
		end else if (paddr == `SCRBM_OFS_REFUSED) begin
			hit_refused = 1'b1;
		end
	end

	assign hit_any = hit_cfg | hit_pos | hit_status | hit_refused;
	assign wr_cfg = wr_lane0 & hit_cfg;
	assign wr_pos = wr_lane0 & hit_pos;
	assign wr_refused = wr_lane0 & hit_refused;

	// ----------------------------------------------------------------
	// Write permission
	// ----------------------------------------------------------------

	// Normal mode: one write inside the window; special mode: always
	assign wdog_wr_ok = special | (win_open & ~wdog_used_ff);
	assign pos_wr_ok = special | (win_open & ~pos_used_ff);
	assign cfg_refuse_ev = wr_cfg & ~wdog_wr_ok;
	assign pos_refuse_ev = wr_pos & ~pos_wr_ok;

	// ----------------------------------------------------------------
	// System configuration register
	// ----------------------------------------------------------------

	// Watchdog disable; reset value follows the caught mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			wdog_dis_ff <= ~mode_b_strap;
		end else if (wr_cfg & wdog_wr_ok) begin
			wdog_dis_ff <= pwdata[`SCRBM_BIT_WDOG_DIS];
		end
	end

	// Once-only latch; only normal mode consumes the single write
	always_ff @(posedge mclk) begin
		if (srst) begin
			wdog_used_ff <= 1'b0;
		end else if (wr_cfg & wdog_wr_ok & ~special) begin
			wdog_used_ff <= 1'b1;
		end
	end

	// ROM map enable: on except in normal expanded mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			rom_en_ff <= ~(mode_b_strap & mode_a_strap);
		end else if (wr_cfg & special) begin
			rom_en_ff <= pwdata[`SCRBM_BIT_ROM_EN];
		end
	end

	// ----------------------------------------------------------------
	// Register block position register
	// ----------------------------------------------------------------

	// Shares the once-in-window policy of the watchdog bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			pos_ff <= `SCRBM_POS_RESET;
		end else if (wr_pos & pos_wr_ok) begin
			pos_ff <= pwdata[`SCRBM_POS_MSB:0];
		end
	end

	// Once-only latch for the position register
	always_ff @(posedge mclk) begin
		if (srst) begin
			pos_used_ff <= 1'b0;
		end else if (wr_pos & pos_wr_ok & ~special) begin
			pos_used_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Refused-write tracking
	// ----------------------------------------------------------------

	// Sticky flags, write one to clear; a new refusal wins over the clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg_refused_ff <= 1'b0;
		end else if (cfg_refuse_ev) begin
			cfg_refused_ff <= 1'b1;
		end else if (wr_refused & pwdata[`SCRBM_RF_CFG]) begin
			cfg_refused_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pos_refused_ff <= 1'b0;
		end else if (pos_refuse_ev) begin
			pos_refused_ff <= 1'b1;
		end else if (wr_refused & pwdata[`SCRBM_RF_POS]) begin
			pos_refused_ff <= 1'b0;
		end
	end

	// Saturating count so a runaway loop cannot wrap it back to zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			refused_cnt_ff <= 8'h00;
		end else if ((cfg_refuse_ev | pos_refuse_ev) && (refused_cnt_ff != `SCRBM_CNT_MAX)) begin
			refused_cnt_ff <= refused_cnt_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Status word shows live mode and window state
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`SCRBM_ST_SPECIAL] = special;
		status_word[`SCRBM_ST_WIN_OPEN] = win_open;
		status_word[`SCRBM_ST_MODE_MSB:`SCRBM_ST_MODE_LSB] = mode_ff;
		status_word[`SCRBM_ST_WDOG_USED] = wdog_used_ff;
		status_word[`SCRBM_ST_POS_USED] = pos_used_ff;
	end

	// Refusal word: flags low, count in the second byte
	always_comb begin
		refused_word = 32'h0000_0000;
		refused_word[`SCRBM_RF_CFG] = cfg_refused_ff;
		refused_word[`SCRBM_RF_POS] = pos_refused_ff;
		refused_word[`SCRBM_RF_CNT_MSB:`SCRBM_RF_CNT_LSB] = refused_cnt_ff;
	end

	// Read mux; both configuration bits readable at any time
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_cfg) begin
			rd_word[`SCRBM_BIT_WDOG_DIS] = wdog_dis_ff;
			rd_word[`SCRBM_BIT_ROM_EN] = rom_en_ff;
		end else if (hit_pos) begin
			rd_word[`SCRBM_POS_MSB:0] = pos_ff;
		end else if (hit_status) begin
			rd_word = status_word;
		end else if (hit_refused) begin
			rd_word = refused_word;
		end
	end

	// Read data and error are captured in the setup cycle, so the
	// access cycle completes at once with registered outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite) begin
			prdata_ff <= rd_word;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pslverr_ff <= 1'b0;
		end else if (setup_ph) begin
			pslverr_ff <= ~hit_any;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff & access_ph;

	// ----------------------------------------------------------------
	// Memory map decode and watchdog gate
	// ----------------------------------------------------------------
	scrbm_decode u_decode (
		.mem_addr(mem_addr),
		.rom_map_enable(rom_en_ff),
		.reg_block_page(pos_ff),
		.regs_sel(regs_sel),
		.rom_sel(rom_sel),
		.regs_offset(regs_offset)
	);

	scrbm_wdog_gate u_wdog_gate (
		.mclk(mclk),
		.srst(srst),
		.wdog_timeout(wdog_timeout),
		.watchdog_disable(wdog_dis_ff),
		.sys_reset_req(sys_reset_req)
	);

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	assign watchdog_disable = wdog_dis_ff;
	assign rom_map_enable = rom_en_ff;
	assign special_mode_flag = special;
	assign register_block_position = pos_ff;

endmodule

`default_nettype wire

// *** scrbm_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Checker for config and map
// ------------------------------
module scrbm_sva #(
	parameter int WIN_CYCLES = 64
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [15:0] mem_addr,
	input wire logic regs_sel,
	input wire logic rom_sel,
	input wire logic [6:0] regs_offset,
	input wire logic wdog_timeout,
	input wire logic sys_reset_req,
	input wire logic watchdog_disable,
	input wire logic rom_map_enable,
	input wire logic special_mode_flag,
	input wire logic [3:0] register_block_position
);
	logic [7:0] win_cnt_ff;
	// Cycles since release; saturates so a long run never reopens the window
	always_ff @(posedge mclk) begin
		if (srst) begin
			win_cnt_ff <= 8'h00;
		end else if (win_cnt_ff != 8'hff) begin
			win_cnt_ff <= win_cnt_ff + 8'h01;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	wdog_fires_a: assert property (wdog_timeout && !watchdog_disable |=> sys_reset_req)
		else $error("timeout gave no reset request");
	wdog_quiet_a: assert property (wdog_timeout && watchdog_disable |=> !sys_reset_req)
		else $error("reset request while watchdog off");
	rom_decode_a: assert property (rom_sel == (rom_map_enable && mem_addr >= 16'hc000 && !regs_sel))
		else $error("rom select wrong");
	regs_page_a: assert property (regs_sel ==
		(mem_addr[15:12] == register_block_position && mem_addr[11:7] == 5'h00))
		else $error("register block select wrong");
	regs_offset_a: assert property (regs_sel |-> regs_offset == mem_addr[6:0])
		else $error("register offset wrong");
	rom_locked_a: assert property (!special_mode_flag |=> $stable(rom_map_enable))
		else $error("rom enable moved in normal mode");
	late_lock_a: assert property (!special_mode_flag && win_cnt_ff > WIN_CYCLES |->
		$stable(watchdog_disable) && $stable(register_block_position))
		else $error("write accepted after window");
	special_write_a: assert property (psel && penable && pwrite && paddr == 8'h00 && pstrb[0]
		&& special_mode_flag |=> {29'h0, watchdog_disable, rom_map_enable, 1'b0} == ($past(pwdata) & 32'h6))
		else $error("special mode write lost");
	reset_vals_a: assert property ($fell(srst) |-> watchdog_disable == special_mode_flag
		&& register_block_position == 4'h1)
		else $error("reset value wrong");
endmodule
bind scrbm_top scrbm_sva #(.WIN_CYCLES(WIN_CYCLES)) u_sva (.mclk(mclk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.mem_addr(mem_addr), .regs_sel(regs_sel), .rom_sel(rom_sel), .regs_offset(regs_offset),
	.wdog_timeout(wdog_timeout), .sys_reset_req(sys_reset_req),
	.watchdog_disable(watchdog_disable), .rom_map_enable(rom_map_enable),
	.special_mode_flag(special_mode_flag), .register_block_position(register_block_position));
`default_nettype wire

// *** tb_system_config_and_reg_block_map.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Bench for config and map
// ------------------------------
module tb_system_config_and_reg_block_map;
	logic mclk, srst, mode_a_strap, mode_b_strap, psel, penable, pwrite, wdog_timeout;
	logic pready, pslverr, regs_sel, rom_sel, sys_reset_req, watchdog_disable, rom_map_enable;
	logic special_mode_flag, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, register_block_position;
	logic [15:0] mem_addr;
	logic [6:0] regs_offset;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;

	scrbm_top uut (.mclk(mclk), .srst(srst), .mode_a_strap(mode_a_strap),
		.mode_b_strap(mode_b_strap), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_addr(mem_addr), .regs_sel(regs_sel), .rom_sel(rom_sel),
		.regs_offset(regs_offset), .wdog_timeout(wdog_timeout), .sys_reset_req(sys_reset_req),
		.watchdog_disable(watchdog_disable), .rom_map_enable(rom_map_enable),
		.special_mode_flag(special_mode_flag), .register_block_position(register_block_position));

	// Clock, 5 ns period
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Hang guard; the whole run needs about 420 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Reset with straps {b,a}; returns at the last edge with reset high
	task automatic do_reset(input logic [1:0] m);
		srst <= 1'b1;
		{mode_b_strap, mode_a_strap} <= m;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
	endtask

	// One transfer; an idle edge after release keeps drivers single per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// Waits for the answer; only the hang guard ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic dec(input logic [15:0] a, input logic s, input logic r);
		mem_addr <= a;
		@(posedge mclk);
		chk({regs_sel, rom_sel}, {s, r});
		chk(regs_offset, a[6:0]);
	endtask

	task automatic t_reset_modes();
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			do_reset(m);
			@(posedge mclk);
			chk(watchdog_disable, !m[1]);
			chk(rom_map_enable, !(m[1] & m[0]));
			chk(register_block_position, 4'h1);
			chk(special_mode_flag, !m[1]);
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, {29'h0, !m[1], !(m[1] & m[0]), 1'b0});
		end
		dec(16'h1000, 1'b1, 1'b0);
		dec(16'h0fff, 1'b0, 1'b0);
		$display("test reset_modes done");
	endtask

	task automatic t_normal_once();
		do_reset(2'b10);
		apb(1'b1, 8'h00, 32'h4);
		chk(watchdog_disable, 1'b1);
		chk(rom_map_enable, 1'b1);
		apb(1'b1, 8'h00, 32'h2);
		chk(watchdog_disable, 1'b1);
		apb(1'b1, 8'h04, 32'h3);
		chk(register_block_position, 4'h3);
		apb(1'b1, 8'h04, 32'h5);
		chk(register_block_position, 4'h3);
		dec(16'h3000, 1'b1, 1'b0);
		// Refusal word: both flags, count of two in the second byte
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0000_0203);
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0000_0202);
		// Status: normal single chip, window open, both once-only rights used
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0000_003a);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		$display("test normal_once done");
	endtask

	// Access at edge 64 is the last one allowed, edge 65 the first refused
	task automatic t_window();
		for (int i = 0; i < 2; i++) begin
			do_reset(2'b11);
			repeat (62 + i) @(posedge mclk);
			apb(1'b1, 8'h00, 32'h6);
			chk(watchdog_disable, i == 0);
			chk(rom_map_enable, 1'b0);
			apb(1'b1, 8'h04, 32'h5);
			chk(register_block_position, 4'h1);
			wdog_timeout <= 1'b1;
			@(posedge mclk);
			wdog_timeout <= 1'b0;
			// Look mid-cycle, once the request flop has settled
			@(negedge mclk);
			chk(sys_reset_req, i == 1);
			@(negedge mclk);
			chk(sys_reset_req, 1'b0);
			@(posedge mclk);
		end
		$display("test window done");
	endtask

	task automatic t_special();
		do_reset(2'b01);
		repeat (80) @(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {29'h0, i[1:0], 1'b0});
			chk(watchdog_disable, i[1]);
			chk(rom_map_enable, i[0]);
		end
		apb(1'b1, 8'h04, 32'hc);
		chk(register_block_position, 4'hc);
		dec(16'hc000, 1'b1, 1'b0);
		dec(16'hc07f, 1'b1, 1'b0);
		dec(16'hc080, 1'b0, 1'b1);
		dec(16'hffff, 1'b0, 1'b1);
		dec(16'hbfff, 1'b0, 1'b0);
		// Lane 0 strobe low: the write must leave both bits alone
		pstrb <= 4'he;
		apb(1'b1, 8'h00, 32'h0);
		chk({watchdog_disable, rom_map_enable}, 2'b11);
		pstrb <= 4'hf;
		apb(1'b1, 8'h00, 32'h0);
		dec(16'hffff, 1'b0, 1'b0);
		$display("test special done");
	endtask

	initial begin
		srst = 1'b1;
		{mode_b_strap, mode_a_strap, psel, penable, pwrite, wdog_timeout} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		mem_addr = 16'h0000;
		t_reset_modes();
		t_normal_once();
		t_window();
		t_special();
		tally_and_finish();
	end
endmodule
`default_nettype wire
